/* File: design/majority_sampler.sv */
// takes one or three samples of the receive line and delivers the voted bit or the centre sample
`timescale 1ns/1ns
`default_nettype none

module majority_sampler
	import rx_timing_recovery_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_rx_data,
	input wire sample_req_s i_req,
	output logic o_bit,
	output logic o_bit_stb
);

	logic early_r;
	logic mid_r;
	wire logic vote;
	wire logic done;

	// majority of three, or centre sample alone
	assign vote = (early_r & mid_r) | (early_r & i_rx_data) | (mid_r & i_rx_data);
	assign done = i_req.multi ? i_req.take_late : i_req.take_mid;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			early_r <= 1'b0;
			mid_r <= 1'b0;
			o_bit <= 1'b0;
			o_bit_stb <= 1'b0;
		end else begin
			if (i_req.take_early)
				early_r <= i_rx_data;
			if (i_req.take_mid)
				mid_r <= i_rx_data;
			o_bit_stb <= done;
			if (done)
				o_bit <= i_req.multi ? vote : i_rx_data; // [RQ10]
		end
	end

endmodule

`default_nettype wire

/* File: design/rx_timing_recovery_ctrl.sv */
// receive timing recovery control, status and sampling window
// Function
// [RQ1] bit 7 reads frame lock on marker channel
// [RQ2] release status reads 0 by default, after clear
// [RQ3] release status 1 from clear command until cleared
// [RQ4] speed bit 0: fast loop, then slow automatically
// [RQ5] speed bit 1: loop always slow
// [RQ6] enable bit runs loop moving sampling window
// [RQ7] window shift limited to quarter bit
// [RQ8] window moves only with independent receive timing
// [RQ9] freeze bit holds loop and sampling point
// [RQ10] multisampling: majority of three, 1.7 us apart
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "rx_timing_recovery_ctrl_regs.svh"

module rx_timing_recovery_ctrl
	import rx_timing_recovery_pkg::*;
#(
	parameter int BIT_CYCLES = `RTR_BIT_CYCLES,
	parameter int MS_SPACING = `RTR_MS_SPACING_CYC,
	parameter int FAST_EDGES = `RTR_FAST_EDGES,
	parameter int FAST_STEP = `RTR_FAST_STEP,
	parameter int SLOW_STEP = `RTR_SLOW_STEP
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [`RTR_ADDR_W-1:0] i_addr,
	input wire logic [`RTR_DATA_W-1:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [`RTR_DATA_W-1:0] o_rd_data,
	input wire logic i_rx_data,
	input wire logic i_frame_lock,
	input wire logic i_lock_clear_cmd,
	input wire logic i_lock_cleared,
	input wire logic i_indep_rx_timing,
	output logic o_rx_bit,
	output logic o_rx_bit_stb,
	output logic signed [11:0] o_window_offset,
	output logic o_loop_slow,
	output logic o_irq
);

	localparam int HALF = BIT_CYCLES / 2;
	localparam int QUARTER = BIT_CYCLES / 4;
	localparam logic [10:0] LAST_CNT = 11'(BIT_CYCLES - 1);
	localparam logic [11:0] HALF_W = 12'(HALF);
	localparam logic [11:0] SPACING_W = 12'(MS_SPACING);
	localparam logic signed [12:0] QUARTER_W = 13'(QUARTER);
	localparam logic signed [12:0] FAST_STEP_W = 13'(FAST_STEP);
	localparam logic signed [12:0] SLOW_STEP_W = 13'(SLOW_STEP);
	localparam logic [5:0] FAST_LAST = 6'(FAST_EDGES - 1);

	// limits a window shift to plus or minus a quarter bit
	function automatic logic signed [11:0] clamp_quarter(input logic signed [12:0] v);
		logic signed [12:0] r;
		r = v;
		if (v > QUARTER_W)
			r = QUARTER_W;
		else if (v < -QUARTER_W)
			r = -QUARTER_W;
		return r[11:0];
	endfunction

	// reset release
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// registers
	ctl_s ctl_r;
	logic release_r;
	logic lock_d_r;
	logic [`RTR_EV_COUNT-1:0] irq_stat_r;
	logic [`RTR_EV_COUNT-1:0] irq_mask_r;

	// loop state
	loop_state_e loop_r;
	loop_state_e loop_nxt;
	logic [10:0] bit_cnt_r;
	logic signed [11:0] offset_r;
	logic signed [11:0] offset_nxt;
	logic [5:0] fast_cnt_r;
	logic rx_d_r;

	// bus decode
	wire logic sel_ctl = (i_addr == `RTR_CTL_ADDR);
	wire logic sel_stat = (i_addr == `RTR_IRQ_STAT_ADDR);
	wire logic sel_mask = (i_addr == `RTR_IRQ_MASK_ADDR);
	wire logic wr_ctl = i_wr_stb & sel_ctl;
	wire logic wr_mask = i_wr_stb & sel_mask;
	wire logic rd_stat = i_rd_stb & sel_stat;

	wire logic [7:0] ctl_view = {i_frame_lock, 1'b0, release_r, 1'b0, ctl_r}; // [RQ1] [RQ2]
	wire logic [7:0] rd_data_nxt = sel_ctl ? ctl_view :
		sel_stat ? {4'h0, irq_stat_r} :
		sel_mask ? {4'h0, irq_mask_r} : 8'h00;

	// loop control decode
	wire logic frozen = ctl_r.freeze_loop_adjust;
	wire logic loop_run = ctl_r.enable & i_indep_rx_timing; // [RQ6] [RQ8]
	wire logic rx_edge = (i_rx_data != rx_d_r);
	wire logic adjust = rx_edge & loop_run & ~frozen & (loop_r != LOOP_OFF); // [RQ9]

	// sampling positions around the shifted centre
	wire logic [11:0] centre = HALF_W + offset_r;
	wire logic [11:0] early_pos = centre - SPACING_W;
	wire logic [11:0] late_pos = centre + SPACING_W;
	wire logic [11:0] cnt_w = {1'b0, bit_cnt_r};
	wire logic signed [12:0] rel = $signed({2'b00, bit_cnt_r}) - $signed({1'b0, centre});

	// edge before centre: window starts early, move it later
	wire logic signed [12:0] step = (loop_r == LOOP_FAST) ? FAST_STEP_W : SLOW_STEP_W; // [RQ4] [RQ5]
	wire logic signed [12:0] offset_wide = {offset_r[11], offset_r};
	wire logic signed [12:0] offset_try = rel[12] ? offset_wide + step : offset_wide - step;

	// events
	wire logic [`RTR_EV_COUNT-1:0] events;
	assign events[`RTR_EV_LOCK_GAINED] = i_frame_lock & ~lock_d_r;
	assign events[`RTR_EV_LOCK_LOST] = ~i_frame_lock & lock_d_r;
	assign events[`RTR_EV_RELEASE_DONE] = release_r & i_lock_cleared;
	assign events[`RTR_EV_SLOW_ENTERED] = (loop_r != LOOP_SLOW) & (loop_nxt == LOOP_SLOW);

	wire sample_req_s req = '{
		take_early: cnt_w == early_pos,
		take_mid: cnt_w == centre,
		take_late: cnt_w == late_pos,
		multi: ctl_r.multi_sample
	};

	always_comb begin
		loop_nxt = loop_r;
		if (!frozen) begin // [RQ9]
			case (loop_r)
				LOOP_OFF: begin
					if (loop_run)
						loop_nxt = ctl_r.speed_low ? LOOP_SLOW : LOOP_FAST; // [RQ4] [RQ5]
				end
				LOOP_FAST: begin
					if (!loop_run)
						loop_nxt = LOOP_OFF;
					else if (ctl_r.speed_low) // [RQ5]
						loop_nxt = LOOP_SLOW;
					else if (adjust && fast_cnt_r == FAST_LAST) // [RQ4]
						loop_nxt = LOOP_SLOW;
				end
				LOOP_SLOW: begin
					if (!loop_run)
						loop_nxt = LOOP_OFF;
				end
				default: begin
					loop_nxt = LOOP_OFF;
				end
			endcase
		end
	end

	always_comb begin
		offset_nxt = offset_r;
		if (frozen)
			offset_nxt = offset_r; // [RQ9]
		else if (!loop_run)
			offset_nxt = 12'sh000; // [RQ6] [RQ8]
		else if (adjust)
			offset_nxt = clamp_quarter(offset_try); // [RQ7]
	end

	// bus side registers
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= ctl_s'(4'(`RTR_CTL_RESET));
			irq_mask_r <= `RTR_EV_COUNT'(`RTR_IRQ_MASK_RESET);
			o_rd_data <= 8'h00;
		end else begin
			if (wr_ctl)
				ctl_r <= i_wr_data[3:0];
			if (wr_mask)
				irq_mask_r <= i_wr_data[`RTR_EV_COUNT-1:0];
			o_rd_data <= i_rd_stb ? rd_data_nxt : 8'h00;
		end
	end

	// status and interrupt flags, a new event wins over the clearing read
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			release_r <= 1'b0;
			lock_d_r <= 1'b0;
			irq_stat_r <= `RTR_EV_COUNT'(`RTR_IRQ_STAT_RESET);
		end else begin
			lock_d_r <= i_frame_lock;
			if (i_lock_clear_cmd)
				release_r <= 1'b1; // [RQ3]
			else if (i_lock_cleared)
				release_r <= 1'b0; // [RQ2] [RQ3]
			irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | events;
		end
	end

	// bit timing and loop
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= 11'h000;
			rx_d_r <= 1'b0;
			loop_r <= LOOP_OFF;
			offset_r <= 12'sh000;
			fast_cnt_r <= 6'h00;
		end else begin
			bit_cnt_r <= (bit_cnt_r == LAST_CNT) ? 11'h000 : bit_cnt_r + 11'h001;
			rx_d_r <= i_rx_data;
			loop_r <= loop_nxt;
			offset_r <= offset_nxt;
			if (loop_nxt != LOOP_FAST)
				fast_cnt_r <= 6'h00;
			else if (adjust)
				fast_cnt_r <= fast_cnt_r + 6'h01; // [RQ4]
		end
	end

	majority_sampler u_sampler (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_rx_data(i_rx_data),
		.i_req(req),
		.o_bit(o_rx_bit),
		.o_bit_stb(o_rx_bit_stb)
	);

	assign o_window_offset = offset_r;
	assign o_loop_slow = (loop_r == LOOP_SLOW);
	assign o_irq = |(irq_stat_r & irq_mask_r);

endmodule

`default_nettype wire

/* File: pkg/rx_timing_recovery_ctrl_regs.svh */
// register map, field positions, reset values and timing counts of the timing recovery block
`ifndef RX_TIMING_RECOVERY_CTRL_REGS_SVH
`define RX_TIMING_RECOVERY_CTRL_REGS_SVH

`define RTR_ADDR_W 16
`define RTR_DATA_W 8

`define RTR_CTL_ADDR 16'hffc8
`define RTR_IRQ_STAT_ADDR 16'hfff0
`define RTR_IRQ_MASK_ADDR 16'hfff4

`define RTR_CTL_RESET 8'h00
`define RTR_IRQ_STAT_RESET 8'h00
`define RTR_IRQ_MASK_RESET 8'h00

`define RTR_BIT_SYNC 7
`define RTR_BIT_SPEED_STAT 6
`define RTR_BIT_RELEASE 5
`define RTR_BIT_FREEZE 3
`define RTR_BIT_MULTI 2
`define RTR_BIT_SPEED_LOW 1
`define RTR_BIT_ENABLE 0

`define RTR_EV_LOCK_GAINED 0
`define RTR_EV_LOCK_LOST 1
`define RTR_EV_RELEASE_DONE 2
`define RTR_EV_SLOW_ENTERED 3
`define RTR_EV_COUNT 4

`define RTR_CLK_HZ 100000000
`define RTR_BIT_RATE_HZ 72000
`define RTR_BIT_CYCLES (`RTR_CLK_HZ / `RTR_BIT_RATE_HZ)
`define RTR_MS_SPACING_NS 1700
`define RTR_MS_SPACING_CYC ((`RTR_MS_SPACING_NS * (`RTR_CLK_HZ / 1000000)) / 1000)
`define RTR_FAST_EDGES 32
`define RTR_FAST_STEP 8
`define RTR_SLOW_STEP 1

`endif

/* File: pkg/rx_timing_recovery_pkg.sv */
// types shared by the timing recovery block
`default_nettype none
package rx_timing_recovery_pkg;

	typedef enum logic [1:0] {
		LOOP_OFF,
		LOOP_FAST,
		LOOP_SLOW
	} loop_state_e;

	typedef struct packed {
		logic freeze_loop_adjust;
		logic multi_sample;
		logic speed_low;
		logic enable;
	} ctl_s;

	typedef struct packed {
		logic take_early;
		logic take_mid;
		logic take_late;
		logic multi;
	} sample_req_s;

endpackage
`default_nettype wire

/* File: sim/radio_rx_model.sv */
// radio transceiver model: serial receive data at the bit rate
`timescale 1ns/1ns
`default_nettype none
module radio_rx_model #(parameter int BITP = 64) (
	input wire logic i_ref_clk,
	input wire logic i_run,
	output logic o_rx_data = 1'b1
);
	int cnt = 0;
	logic [7:0] pat = 8'hb4;
	// idle line rests high between bursts
	always @(posedge i_ref_clk) begin
		cnt <= (cnt == BITP - 1) ? 0 : cnt + 1;
		if (cnt == 20) pat <= {pat[6:0], pat[7]};
		o_rx_data <= i_run ? pat[7] : 1'b1;
	end
endmodule
`default_nettype wire

/* File: sim/rtr_chk_sva.sv */
// assertion checker for the timing recovery block
`timescale 1ns/1ns
`default_nettype none
module rtr_chk #(parameter int BIT_CYCLES = 64) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [7:0] o_rd_data,
	input wire logic i_frame_lock,
	input wire logic i_lock_clear_cmd,
	input wire logic i_lock_cleared,
	input wire logic i_indep_rx_timing,
	input wire logic o_rx_bit_stb,
	input wire logic signed [11:0] o_window_offset,
	input wire logic o_loop_slow
);
	localparam int QB = BIT_CYCLES / 4;
	wire logic rd_ctl = i_rd_stb && i_addr == 16'hffc8;
	wire logic wr_ctl = i_wr_stb && i_addr == 16'hffc8;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	property p_sync; rd_ctl |=> o_rd_data[7] == $past(i_frame_lock); endproperty
	a_sync: assert property (p_sync) else $error("sync bit wrong");
	property p_rel_clr; i_lock_cleared && !i_lock_clear_cmd ##1 rd_ctl && !i_lock_clear_cmd |=> !o_rd_data[5]; endproperty
	a_rel_clr: assert property (p_rel_clr) else $error("release bit not cleared");
	property p_rel_set; i_lock_clear_cmd && !i_lock_cleared ##1 rd_ctl && !i_lock_cleared |=> o_rd_data[5]; endproperty
	a_rel_set: assert property (p_rel_set) else $error("release bit not set");
	property p_fast; wr_ctl && i_wr_data[3:0] == 4'h1 && i_indep_rx_timing && !o_loop_slow |=> !o_loop_slow [*2]; endproperty
	a_fast: assert property (p_fast) else $error("loop not starting fast");
	property p_slow; wr_ctl && i_wr_data[3:0] == 4'h3 && i_indep_rx_timing |=> ##[0:2] o_loop_slow; endproperty
	a_slow: assert property (p_slow) else $error("forced slow missing");
	property p_off; wr_ctl && !i_wr_data[3] && !i_wr_data[0] |=> ##[1:2] o_window_offset == 12'sh0 && !o_loop_slow; endproperty
	a_off: assert property (p_off) else $error("disabled loop still active");
	property p_quarter; $signed(o_window_offset) <= QB && $signed(o_window_offset) >= -QB; endproperty
	a_quarter: assert property (p_quarter) else $error("window shift beyond quarter bit");
	property p_indep; $changed(o_window_offset) && o_window_offset != 12'sh0 |-> $past(i_indep_rx_timing); endproperty
	a_indep: assert property (p_indep) else $error("window moved without independent timing");
	property p_hold; wr_ctl && i_wr_data[3] |=> ##2 $stable(o_window_offset) [*8]; endproperty
	a_hold: assert property (p_hold) else $error("frozen window moved");
	property p_stb; o_rx_bit_stb |=> !o_rx_bit_stb; endproperty
	a_stb: assert property (p_stb) else $error("bit strobe longer than a cycle");
endmodule
bind rx_timing_recovery_ctrl rtr_chk #(.BIT_CYCLES(BIT_CYCLES)) chk (.i_ref_clk, .i_rst_b, .i_addr, .i_wr_data,
	.i_wr_stb, .i_rd_stb, .o_rd_data, .i_frame_lock, .i_lock_clear_cmd, .i_lock_cleared, .i_indep_rx_timing,
	.o_rx_bit_stb, .o_window_offset, .o_loop_slow);
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the timing recovery block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic i_ref_clk = 0, i_rst_b = 0, i_wr_stb = 0, i_rd_stb = 0, i_frame_lock = 0, i_lock_clear_cmd = 0;
	logic i_lock_cleared = 0, i_indep_rx_timing = 0, run = 0;
	logic [15:0] i_addr = 0;
	logic [7:0] i_wr_data = 0, o_rd_data;
	logic i_rx_data, o_rx_bit, o_rx_bit_stb, o_loop_slow, o_irq;
	logic signed [11:0] o_window_offset, held;
	int errors = 0, total_checks = 0, n;
	// write value, expected read-back
	logic [15:0] rows [5] = '{16'h0000, 16'h0f0f, 16'hff0f, 16'h0202, 16'h0c0c};
	rx_timing_recovery_ctrl #(.BIT_CYCLES(64), .MS_SPACING(8), .FAST_EDGES(4)) uut (.i_ref_clk, .i_rst_b,
		.i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data, .i_rx_data, .i_frame_lock, .i_lock_clear_cmd,
		.i_lock_cleared, .i_indep_rx_timing, .o_rx_bit, .o_rx_bit_stb, .o_window_offset, .o_loop_slow, .o_irq);
	radio_rx_model #(.BITP(64)) rm (.i_ref_clk, .i_run(run), .o_rx_data(i_rx_data));
	always #5 i_ref_clk = ~i_ref_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_stb <= 1;
		@(posedge i_ref_clk);
		i_wr_stb <= 0;
		@(posedge i_ref_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd_stb <= 1;
		@(posedge i_ref_clk);
		i_rd_stb <= 0;
		@(negedge i_ref_clk);
		chk(o_rd_data, e);
		@(posedge i_ref_clk);
	endtask
	task automatic conclude;
		$display("errors=%0d checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst_b <= 1;
		repeat (3) @(posedge i_ref_clk);
		foreach (rows[i]) begin
			wr(16'hffc8, rows[i][15:8]);
			rd(16'hffc8, rows[i][7:0]);
		end
		i_rst_b <= 0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_b <= 1;
		repeat (3) @(posedge i_ref_clk);
		rd(16'hffc8, 8'h00);
		rd(16'hfff0, 8'h00);
		rd(16'hfff4, 8'h00);
		wr(16'hffc9, 8'hff);
		rd(16'hffc9, 8'h00);
		i_frame_lock <= 1;
		rd(16'hffc8, 8'h80);
		i_lock_clear_cmd <= 1;
		@(posedge i_ref_clk);
		i_lock_clear_cmd <= 0;
		rd(16'hffc8, 8'ha0);
		i_lock_cleared <= 1;
		@(posedge i_ref_clk);
		i_lock_cleared <= 0;
		rd(16'hffc8, 8'h80);
		i_frame_lock <= 0;
		wr(16'hfff4, 8'h07);
		@(negedge i_ref_clk);
		chk(o_irq, 1);
		@(posedge i_ref_clk);
		rd(16'hfff0, 8'h07);
		@(negedge i_ref_clk);
		chk(o_irq, 0);
		@(posedge i_ref_clk);
		rd(16'hfff0, 8'h00);
		wr(16'hfff4, 8'h00);
		run <= 1;
		i_indep_rx_timing <= 1;
		wr(16'hffc8, 8'h01);
		@(negedge i_ref_clk);
		chk(o_loop_slow, 0);
		for (n = 0; n < 5000 && o_loop_slow !== 1; n++) @(negedge i_ref_clk);
		chk(o_loop_slow, 1);
		chk(o_window_offset <= 16 && o_window_offset >= -16, 1);
		@(posedge i_ref_clk);
		rd(16'hfff0, 8'h08);
		wr(16'hffc8, 8'h00);
		@(negedge i_ref_clk);
		chk(o_loop_slow, 0);
		chk(o_window_offset, 0);
		@(posedge i_ref_clk);
		wr(16'hffc8, 8'h03);
		@(negedge i_ref_clk);
		chk(o_loop_slow, 1);
		repeat (300) @(negedge i_ref_clk);
		// a few single-clock steps, never a fast jump
		chk(o_window_offset != 0 && o_window_offset < 8 && o_window_offset > -8, 1);
		@(posedge i_ref_clk);
		wr(16'hffc8, 8'h0b);
		repeat (2) @(negedge i_ref_clk);
		held = o_window_offset;
		repeat (300) @(negedge i_ref_clk);
		chk(o_window_offset, held);
		chk(o_loop_slow, 1);
		@(posedge i_ref_clk);
		i_indep_rx_timing <= 0;
		wr(16'hffc8, 8'h01);
		repeat (300) @(negedge i_ref_clk);
		chk(o_window_offset, 0);
		chk(o_loop_slow, 0);
		@(posedge i_ref_clk);
		i_indep_rx_timing <= 1;
		run <= 0;
		wr(16'hffc8, 8'h05);
		repeat (70) @(negedge i_ref_clk);
		for (n = 0; n < 200 && o_rx_bit_stb !== 1; n++) @(negedge i_ref_clk);
		chk(o_rx_bit_stb, 1);
		chk(o_rx_bit, 1);
		conclude;
	end
endmodule
`default_nettype wire
